// ===== hw/gcr_pkg.sv
package gcr_pkg;

   // Register indices
   localparam logic [7:0] GCR_IDX_SOFT_RESET  = 8'h02;
   localparam logic [7:0] GCR_IDX_RUN_INDEX   = 8'h03;
   localparam logic [7:0] GCR_IDX_FUNC_SEL    = 8'h07;
   localparam logic [7:0] GCR_IDX_PART_ID     = 8'h20;
   localparam logic [7:0] GCR_IDX_REVISION    = 8'h21;
   localparam logic [7:0] GCR_IDX_POWER_EN    = 8'h22;
   localparam logic [7:0] GCR_IDX_AUTO_PWR    = 8'h23;

   // Field positions and masks
   localparam int         GCR_SOFT_RESET_BIT  = 0;
   localparam int         GCR_RUN_ACCESS_BIT  = 7;
   localparam logic [7:0] GCR_RUN_INDEX_MASK  = 8'h83;
   localparam logic [7:0] GCR_POWER_MASK      = 8'h39;

   // Reset values
   localparam logic [7:0] GCR_RUN_INDEX_RST   = 8'h03;
   localparam logic [7:0] GCR_FUNC_SEL_RST    = 8'h00;
   localparam logic [7:0] GCR_POWER_EN_RST    = 8'h00;
   localparam logic [7:0] GCR_AUTO_PWR_RST    = 8'h00;

   // Run-mode general-purpose index port addresses
   localparam logic [7:0] GCR_GP_ADDR_11      = 8'hea;
   localparam logic [7:0] GCR_GP_ADDR_01      = 8'he2;
   localparam logic [7:0] GCR_GP_ADDR_00      = 8'he0;

   // Identity values, arbitrary
   localparam logic [7:0] GCR_PART_ID_DEF     = 8'h5a;
   localparam logic [7:0] GCR_REVISION_DEF    = 8'h01;

   typedef struct packed {
      logic       indexWr;
      logic       dataWr;
      logic       dataRd;
      logic [7:0] wrData;
   } gcr_host_t;

   typedef struct packed {
      logic [7:0] powerEnable;
      logic [7:0] autoPower;
      logic [7:0] functionSelect;
      logic [7:0] runIndexAddr;
      logic       runAccessEn;
   } gcr_cfg_t;

endpackage

// ===== hw/gcr_field_reg.sv
`timescale 1ns/10ps
module gcr_field_reg
   import gcr_pkg::*;
#(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] MASK    = 8'hff
)(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       softRst,
   input  wire logic       wrEn,
   input  wire logic [7:0] wrData,
   output logic      [7:0] value
);
   logic [7:0] value_r;
   logic [7:0] value_nxt;

   // Unimplemented bits stay zero
   assign value_nxt = softRst ? RST_VAL : (wrData & MASK);
   assign value     = value_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         value_r <= RST_VAL;
      end else if (softRst || wrEn) begin
         value_r <= value_nxt;
      end
   end
endmodule

// ===== hw/gcr_global_config.sv
`timescale 1ns/10ps
// Functional notes
// RULE1 - Full eight-bit index decode, no aliasing
// RULE2 - Unimplemented registers and bits read zero
// RULE3 - Index write selects, data port accesses it
// RULE4 - Access only in configuration mode
// RULE5 - Reserved low locations ignore writes, read zero
// RULE6 - Soft reset bit reloads defaults, self-clears
// RULE7 - Bit 7 opens run-mode watchdog, management access
// RULE8 - Bits 1:0 choose run-mode index address
// RULE9 - Write 0x07 selects current logical device
// RULE10 - Activate affects selected device only
// RULE11 - 0x20 hard-wired part identification, read-only
// RULE12 - 0x21 returns silicon revision
// RULE13 - 0x22 function power bits, soft-reset clears
// RULE14 - 0x23 automatic power management enables
// RULE15 - 0x23 bits 7:6 read zero
// RULE16 - Revision is a design parameter
module gcr_global_config
   import gcr_pkg::*;
#(
   parameter logic [7:0] PART_ID  = GCR_PART_ID_DEF,
   parameter logic [7:0] REVISION = GCR_REVISION_DEF // RULE16
)(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       configMode,
   input  wire gcr_host_t  host,
   input  wire logic       activateCmd,
   output logic      [7:0] rdData,
   output logic            rdValid,
   output gcr_cfg_t        cfg,
   output logic            softResetPulse,
   output logic            activateStrobe,
   output logic      [7:0] activateTarget
);

   ////////////////////////////////////////////////////////////////////////
   // Index register and decode

   logic [7:0] index_r;
   logic [7:0] rdData_r;
   logic       rdValid_r;
   logic       softReset_r;
   logic       activate_r;
   logic [7:0] actTarget_r;
   logic [7:0] gpAddr_r;

   logic       idxWr;
   logic       dWr;
   logic       dRd;
   logic       selRunIdx;
   logic       selFunc;
   logic       selPower;
   logic       selAuto;
   logic       softRstReq;
   logic [7:0] runIdxVal;
   logic [7:0] funcVal;
   logic [7:0] powerVal;
   logic [7:0] autoVal;
   logic [7:0] rdMux;
   logic [7:0] gpAddrNxt;

   // Ports ignored outside configuration mode
   assign idxWr = host.indexWr && configMode;                 // RULE4
   assign dWr   = host.dataWr && configMode;                  // RULE4 RULE3
   assign dRd   = host.dataRd && configMode;                  // RULE4 RULE3

   // Exact match on all eight bits
   assign selRunIdx = (index_r == GCR_IDX_RUN_INDEX);         // RULE1
   assign selFunc   = (index_r == GCR_IDX_FUNC_SEL);          // RULE1
   assign selPower  = (index_r == GCR_IDX_POWER_EN);          // RULE1
   assign selAuto   = (index_r == GCR_IDX_AUTO_PWR);          // RULE1

   assign softRstReq = dWr && (index_r == GCR_IDX_SOFT_RESET)
                       && host.wrData[GCR_SOFT_RESET_BIT];    // RULE6

   always_ff @(posedge clk) begin
      if (srst) begin
         index_r <= 8'h00;
      end else if (idxWr) begin
         index_r <= host.wrData;                              // RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage registers

   gcr_field_reg #(
      .RST_VAL (GCR_RUN_INDEX_RST),
      .MASK    (GCR_RUN_INDEX_MASK)
   ) u_run_idx (
      .clk     (clk),
      .srst    (srst),
      .softRst (softRstReq),
      .wrEn    (dWr && selRunIdx),
      .wrData  (host.wrData),
      .value   (runIdxVal)
   );

   gcr_field_reg #(
      .RST_VAL (GCR_FUNC_SEL_RST),
      .MASK    (8'hff)
   ) u_func_sel (
      .clk     (clk),
      .srst    (srst),
      .softRst (softRstReq),
      .wrEn    (dWr && selFunc),                              // RULE9
      .wrData  (host.wrData),
      .value   (funcVal)
   );

   gcr_field_reg #(
      .RST_VAL (GCR_POWER_EN_RST),
      .MASK    (GCR_POWER_MASK)
   ) u_power (
      .clk     (clk),
      .srst    (srst),
      .softRst (softRstReq),                                  // RULE13
      .wrEn    (dWr && selPower),
      .wrData  (host.wrData),
      .value   (powerVal)
   );

   // Same field layout as the power register; top bits masked off
   gcr_field_reg #(
      .RST_VAL (GCR_AUTO_PWR_RST),
      .MASK    (GCR_POWER_MASK)                               // RULE15
   ) u_auto (
      .clk     (clk),
      .srst    (srst),
      .softRst (softRstReq),
      .wrEn    (dWr && selAuto),                              // RULE14
      .wrData  (host.wrData),
      .value   (autoVal)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path; anything not listed returns zero

   always_comb begin
      unique case (index_r)
         GCR_IDX_RUN_INDEX: rdMux = runIdxVal;
         GCR_IDX_FUNC_SEL:  rdMux = funcVal;
         GCR_IDX_PART_ID:   rdMux = PART_ID;                  // RULE11
         GCR_IDX_REVISION:  rdMux = REVISION;                 // RULE12
         GCR_IDX_POWER_EN:  rdMux = powerVal;
         GCR_IDX_AUTO_PWR:  rdMux = autoVal;
         default:           rdMux = 8'h00;                    // RULE2 RULE5
      endcase
   end

   // Two-bit code to port address; code 10 is unspecified, kept at default
   assign gpAddrNxt = (runIdxVal[1:0] == 2'b01) ? GCR_GP_ADDR_01 :
                      (runIdxVal[1:0] == 2'b00) ? GCR_GP_ADDR_00 :
                                                 GCR_GP_ADDR_11; // RULE8

   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_r    <= 8'h00;
         rdValid_r   <= 1'b0;
         softReset_r <= 1'b0;
         activate_r  <= 1'b0;
         actTarget_r <= 8'h00;
         gpAddr_r    <= GCR_GP_ADDR_11;
      end else begin
         rdData_r    <= dRd ? rdMux : 8'h00;
         rdValid_r   <= dRd;
         // One-cycle pulse, so the bit is never seen set
         softReset_r <= softRstReq;                           // RULE6
         activate_r  <= activateCmd && configMode;            // RULE10
         actTarget_r <= funcVal;                              // RULE10
         gpAddr_r    <= gpAddrNxt;                            // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rdData         = rdData_r;
   assign rdValid        = rdValid_r;
   assign softResetPulse = softReset_r;
   assign activateStrobe = activate_r;
   assign activateTarget = actTarget_r;
   assign cfg.powerEnable    = powerVal;
   assign cfg.autoPower      = autoVal;
   assign cfg.functionSelect = funcVal;
   assign cfg.runIndexAddr   = gpAddr_r;
   assign cfg.runAccessEn    = runIdxVal[GCR_RUN_ACCESS_BIT]; // RULE7

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_idx(logic [7:0] v);
      idxWr && host.wrData == v;
   endsequence

   sequence s_reloaded;
      softResetPulse && powerVal == GCR_POWER_EN_RST
      && runIdxVal == GCR_RUN_INDEX_RST && funcVal == GCR_FUNC_SEL_RST;
   endsequence

   // A second request straight after keeps the pulse high legally
   sequence s_self_clear;
      !softResetPulse || $past(softRstReq);
   endsequence

   property p_soft_reset;
      @(posedge clk) disable iff (srst)
      softRstReq |=> s_reloaded ##1 s_self_clear;
   endproperty
   a_soft_reset: assert property (p_soft_reset)                // RULE6
      else $error("soft reset did not reload defaults");

   property p_no_cfg;
      @(posedge clk) disable iff (srst)
      !configMode |=> !rdValid && !activateStrobe && $stable(index_r);
   endproperty
   a_no_cfg: assert property (p_no_cfg)                        // RULE4
      else $error("access taken outside configuration mode");

   property p_part_id;
      @(posedge clk) disable iff (srst)
      s_idx(GCR_IDX_PART_ID) ##1 dRd |=> rdData == PART_ID;
   endproperty
   a_part_id: assert property (p_part_id)                      // RULE11
      else $error("part id read wrong");

   property p_rev;
      @(posedge clk) disable iff (srst)
      dRd && index_r == GCR_IDX_REVISION |=> rdData == REVISION;
   endproperty
   a_rev: assert property (p_rev)                              // RULE12
      else $error("revision read wrong");

   property p_reserved;
      @(posedge clk) disable iff (srst)
      dRd && (index_r < GCR_IDX_SOFT_RESET || index_r > GCR_IDX_AUTO_PWR
              || (index_r > GCR_IDX_RUN_INDEX
                  && index_r < GCR_IDX_FUNC_SEL)
              || (index_r > GCR_IDX_FUNC_SEL
                  && index_r < GCR_IDX_PART_ID))
      |=> rdData == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved)                    // RULE5
      else $error("reserved location read nonzero");

   property p_alias;
      @(posedge clk) disable iff (srst)
      dRd && index_r[5:0] == GCR_IDX_PART_ID[5:0]
      && index_r[7:6] != 2'b00 |=> rdData == 8'h00;
   endproperty
   a_alias: assert property (p_alias)                          // RULE1
      else $error("index aliasing seen");

   property p_auto_top;
      @(posedge clk) disable iff (srst)
      dWr && selAuto |=> autoVal[7:6] == 2'b00
                         && autoVal[0] == $past(host.wrData[0]);
   endproperty
   a_auto_top: assert property (p_auto_top)                    // RULE15
      else $error("auto power top bits set");

   property p_func;
      @(posedge clk) disable iff (srst)
      dWr && selFunc && !softRstReq
      |=> funcVal == $past(host.wrData) ##1 actTarget_r == $past(funcVal);
   endproperty
   a_func: assert property (p_func)                            // RULE9
      else $error("function select not stored");

   property p_gp;
      @(posedge clk) disable iff (srst)
      runIdxVal[1:0] == 2'b00 ##1 runIdxVal[1:0] == 2'b00
      |-> cfg.runIndexAddr == GCR_GP_ADDR_00;
   endproperty
   a_gp: assert property (p_gp)                                // RULE8
      else $error("run-mode index address wrong");

   property p_gp_e2;
      @(posedge clk) disable iff (srst)
      runIdxVal[1:0] == 2'b01 ##1 runIdxVal[1:0] == 2'b01
      |-> cfg.runIndexAddr == GCR_GP_ADDR_01;
   endproperty
   a_gp_e2: assert property (p_gp_e2)                          // RULE8
      else $error("run-mode index address code 01 wrong");

   // Back-to-back reads keep the valid flag high
   property p_rd_answer;
      @(posedge clk) disable iff (srst)
      dRd |=> rdValid ##1 (!rdValid || $past(dRd));
   endproperty
   a_rd_answer: assert property (p_rd_answer)                  // RULE3
      else $error("read answer not a single pulse");

   property p_activate;
      @(posedge clk) disable iff (srst)
      activateCmd && configMode |=> activateStrobe
                                    && activateTarget == $past(funcVal);
   endproperty
   a_activate: assert property (p_activate)                    // RULE10
      else $error("activate not aimed at selected device");

   property p_wo_read;
      @(posedge clk) disable iff (srst)
      dRd && index_r == GCR_IDX_SOFT_RESET |=> rdData == 8'h00;
   endproperty
   a_wo_read: assert property (p_wo_read)                      // RULE6
      else $error("soft reset register read nonzero");

   property p_power_bits;
      @(posedge clk) disable iff (srst)
      dWr && selPower |=> powerVal == ($past(host.wrData) & GCR_POWER_MASK);
   endproperty
   a_power_bits: assert property (p_power_bits)                // RULE13
      else $error("power register bits wrong");

endmodule

// ===== sim/gcr_host_model.sv
`timescale 1ns/10ps
module gcr_host_model
   import gcr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdData,
   input  wire logic       rdValid,
   output gcr_host_t       host
);
   initial begin
      host = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One strobe per call, held one cycle: kind picks index write, data write or data read
   task automatic put(input logic [2:0] kind, input logic [7:0] d);
      @(posedge clk);
      host.indexWr <= kind[2];
      host.dataWr  <= kind[1];
      host.dataRd  <= kind[0];
      host.wrData  <= d;
      @(posedge clk);
      host.indexWr <= 1'b0;
      host.dataWr  <= 1'b0;
      host.dataRd  <= 1'b0;
      // Released bus must not keep showing the last byte
      host.wrData  <= ~d;
   endtask
   task automatic dat_rd(output logic [7:0] d, output logic ok);
      put(3'b001, 8'h00);
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 4 && !ok; i++) begin
         #1;
         if (rdValid === 1'b1) begin
            ok = 1'b1;
            d = rdData;
         end else begin
            @(posedge clk);
         end
      end
   endtask
endmodule

// ===== sim/gcr_global_config_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module gcr_global_config_tb_top
   import gcr_pkg::*;
;
   localparam logic [7:0] PID = 8'h3c; // Arbitrary value
   localparam logic [7:0] REV = 8'h07; // Arbitrary value
   logic       clk;
   logic       srst;
   logic       configMode;
   logic       activateCmd;
   gcr_host_t  host;
   logic [7:0] rdData;
   logic       rdValid;
   gcr_cfg_t   cfg;
   logic       softResetPulse;
   logic       activateStrobe;
   logic [7:0] activateTarget;
   int         bad_count;
   int         n_compared;
   logic [7:0] idxT[7] = '{8'h02, 8'h03, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23};
   logic [7:0] rstT[7] = '{8'h00, 8'h03, 8'h00, PID, REV, 8'h00, 8'h00};
   logic [7:0] fulT[7] = '{8'h00, 8'h83, 8'hff, PID, REV, 8'h39, 8'h39};
   logic [7:0] gpT[4]  = '{8'he0, 8'he2, 8'hea, 8'hea};
   logic [7:0] d;
   logic       ok;

   gcr_global_config #(.PART_ID(PID), .REVISION(REV)) dut (
      .clk(clk), .srst(srst), .configMode(configMode), .host(host),
      .activateCmd(activateCmd), .rdData(rdData), .rdValid(rdValid),
      .cfg(cfg), .softResetPulse(softResetPulse),
      .activateStrobe(activateStrobe), .activateTarget(activateTarget));
   gcr_host_model hm (.clk(clk), .rdData(rdData), .rdValid(rdValid),
      .host(host));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      hm.put(3'b100, i);
      hm.put(3'b010, v);
   endtask
   task automatic chk_rd(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] r;
      logic       k;
      hm.put(3'b100, i);
      hm.dat_rd(r, k);
      if (k !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t read not answered", $time);
         final_report();
      end else begin
         `CHK(r, e)
      end
   endtask
   task automatic pulse_act();
      @(posedge clk);
      activateCmd <= 1'b1;
      @(posedge clk);
      activateCmd <= 1'b0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      bad_count = 0;
      n_compared = 0;
      srst = 1'b1;
      configMode = 1'b0;
      activateCmd = 1'b0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      configMode <= 1'b1;
      for (int k = 0; k < 7; k++) chk_rd(idxT[k], rstT[k]);
      `CHK(cfg.runIndexAddr, GCR_GP_ADDR_11)
      `CHK(cfg.runAccessEn, 1'b0)
      $display("test defaults done");
      for (int i = 0; i < 36; i++) if (i != 2) wr(8'(i), 8'hff);
      for (int k = 0; k < 7; k++) chk_rd(idxT[k], fulT[k]);
      for (int i = 0; i < 32; i++) begin
         if (i != 2 && i != 3 && i != 7) chk_rd(8'(i), 8'h00);
      end
      wr(8'h83, 8'h00);
      wr(8'ha3, 8'h00);
      chk_rd(8'h03, 8'h83);
      chk_rd(8'h23, 8'h39);
      chk_rd(8'ha3, 8'h00);
      chk_rd(8'he0, 8'h00);
      `CHK(cfg.runAccessEn, 1'b1)
      `CHK(cfg.autoPower, 8'h39)
      $display("test full write done");
      for (int c = 0; c < 4; c++) begin
         wr(8'h03, 8'(c));
         @(posedge clk);
         #1;
         `CHK(cfg.runIndexAddr, gpT[c])
      end
      $display("test index codes done");
      wr(8'h07, 8'h05);
      #1;
      `CHK(cfg.functionSelect, 8'h05)
      pulse_act();
      `CHK(activateStrobe, 1'b1)
      `CHK(activateTarget, 8'h05)
      @(posedge clk);
      configMode <= 1'b0;
      wr(8'h22, 8'h00);
      hm.put(3'b100, 8'h22);
      hm.dat_rd(d, ok);
      `CHK(ok, 1'b0)
      pulse_act();
      `CHK(activateStrobe, 1'b0)
      @(posedge clk);
      configMode <= 1'b1;
      chk_rd(8'h22, 8'h39);
      $display("test activate and mode done");
      wr(8'h03, 8'h81);
      wr(8'h02, 8'h01);
      #1;
      `CHK(softResetPulse, 1'b1)
      `CHK(cfg.powerEnable, 8'h00)
      `CHK(cfg.functionSelect, 8'h00)
      `CHK(cfg.autoPower, 8'h00)
      `CHK(cfg.runAccessEn, 1'b0)
      chk_rd(8'h02, 8'h00);
      chk_rd(8'h03, 8'h03);
      `CHK(cfg.runIndexAddr, GCR_GP_ADDR_11)
      $display("test soft reset done");
      final_report();
   end
endmodule
